// ### inc/asr_map.svh
// Constants for the alarm setpoint and relay block: register map, field
// layout, reset values and timing. Included by the package and design files.
`ifndef ASR_MAP_SVH
`define ASR_MAP_SVH

// Sizes
`define ASR_ALARMS 8
`define ASR_RELAYS 7
`define ASR_VAL_W 24
`define ASR_TIME_W 16
`define ASR_PI_ALARMS 2
`define ASR_PI_W 16

// Byte address layout: [9:8] region, [7:5] alarm, [4:2] field
`define ASR_REGION_ALARM 2'h0
`define ASR_REGION_PI 2'h1
`define ASR_F_UPPER 3'h0
`define ASR_F_LOWER 3'h1
`define ASR_F_ENABLE 3'h2
`define ASR_F_DEADBAND 3'h3
`define ASR_F_TRIP 3'h4
`define ASR_F_RELEASE 3'h5
`define ASR_F_ALLOC 3'h6
`define ASR_F_STATUS 3'h7
`define ASR_EN_UPPER_BIT 0
`define ASR_EN_LOWER_BIT 1

// Control parameter words in the PI region: [6] alarm, [5:2] index
`define ASR_PI_SPAN 4'h0
`define ASR_PI_TARGET 4'h1
`define ASR_PI_PGAIN 4'h2
`define ASR_PI_IGAIN 4'h3
`define ASR_PI_IHIGH 4'h4
`define ASR_PI_ILOW 4'h5
`define ASR_PI_BIAS 4'h6
`define ASR_PI_CYCLE 4'h7
`define ASR_PI_ONTIME 4'h8
`define ASR_PI_WORDS 9

// Reset values and maxima (percent and seconds in tenths, gains in thousandths)
`define ASR_RST_DEADBAND 16'h000A
`define ASR_MAX_DEADBAND 16'hC350
`define ASR_MAX_TIME 16'hC350
`define ASR_RST_SPAN 16'h03E8
`define ASR_RST_TARGET 16'h03E8
`define ASR_RST_PGAIN 16'h000A
`define ASR_RST_ILIMIT 16'h03E8
`define ASR_RST_BIAS 16'h01F4

// Timing: delay tick of 0.1 s, clock period 100 ns, flash half period in ticks
`define ASR_TICK_NS 100000000
`define ASR_CLK_NS 100
`define ASR_FLASH_TICKS 3'h5

`endif

// ### inc/asr_pkg.sv
// Types shared by the alarm setpoint and relay block.
// Assumes asr_map.svh is on the include path.
`include "asr_map.svh"

package asr_pkg;

   // Settings held for one alarm channel
   typedef struct packed {
      logic hi_en;
      logic lo_en;
      logic signed [`ASR_VAL_W-1:0] hi;
      logic signed [`ASR_VAL_W-1:0] lo;
      logic [`ASR_TIME_W-1:0] deadband_amount;
      logic [`ASR_TIME_W-1:0] trip;
      logic [`ASR_TIME_W-1:0] release_dly;
      logic [`ASR_RELAYS-1:0] relay_allocation;
   } asr_cfg_t;

   // Delay state of one alarm channel
   typedef enum logic [1:0] {
      ASR_IDLE,
      ASR_TRIPPING,
      ASR_ACTIVE,
      ASR_RELEASING
   } asr_state_t;

   // Live state of one channel, as reported in its status word
   typedef struct packed {
      logic lit;
      logic acked;
      logic active;
      logic cond;
   } asr_status_t;

endpackage

// ### logic/asr_chan.sv
// One alarm channel: setpoint compare with deadband, trip and release delays.
// Assumes value comes from logic on clk and tick is a one-cycle 0.1 s pulse.
`timescale 1ns/1ps
`include "asr_map.svh"

module asr_chan (
   input wire logic clk, // System clock
   input wire logic sys_rst, // Synchronous reset, active high
   input wire logic signed [`ASR_VAL_W-1:0] value, // Displayed value
   input asr_pkg::asr_cfg_t cfg, // Channel settings
   input wire logic tick, // Delay time base pulse
   output logic cond, // Alarm condition after deadband
   output logic active // Delayed alarm output
);

   localparam int XW = `ASR_VAL_W + 2;

   logic hi_flag, lo_flag, next_hi_flag, next_lo_flag;
   asr_pkg::asr_state_t state, next_state;
   logic [`ASR_TIME_W-1:0] cnt, next_cnt;
   logic signed [XW-1:0] val_x, hi_x, lo_x, band_x;

   assign val_x = XW'(value);
   assign hi_x = XW'(cfg.hi);
   assign lo_x = XW'(cfg.lo);
   assign band_x = $signed({{(XW-`ASR_TIME_W){1'b0}}, cfg.deadband_amount});

   // Setpoint flags: set at the level, release only past the deadband
   always_comb begin
      next_hi_flag = hi_flag;
      next_lo_flag = lo_flag;
      if (!cfg.hi_en) begin
         next_hi_flag = 1'b0;
      end else if (val_x >= hi_x) begin
         next_hi_flag = 1'b1;
      end else if (val_x < hi_x - band_x) begin
         next_hi_flag = 1'b0;
      end
      if (!cfg.lo_en) begin
         next_lo_flag = 1'b0;
      end else if (val_x <= lo_x) begin
         next_lo_flag = 1'b1;
      end else if (val_x > lo_x + band_x) begin
         next_lo_flag = 1'b0;
      end
   end

   // Overlapping setpoints alarm inside the band, otherwise outside it
   assign cond = (cfg.hi_en && cfg.lo_en && (hi_x < lo_x)) ?
                 (hi_flag && lo_flag) : (hi_flag || lo_flag);

   // Delay sequencer; a zero delay acts in the next cycle
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      unique case (state)
         asr_pkg::ASR_IDLE: begin
            if (cond) begin
               next_cnt = '0;
               next_state = (cfg.trip == '0) ? asr_pkg::ASR_ACTIVE : asr_pkg::ASR_TRIPPING;
            end
         end
         asr_pkg::ASR_TRIPPING: begin
            if (!cond) begin
               next_state = asr_pkg::ASR_IDLE;
            end else if (tick) begin
               next_cnt = cnt + 16'h0001;
               if (next_cnt >= cfg.trip) begin
                  next_state = asr_pkg::ASR_ACTIVE;
               end
            end
         end
         asr_pkg::ASR_ACTIVE: begin
            if (!cond) begin
               next_cnt = '0;
               next_state = (cfg.release_dly == '0) ? asr_pkg::ASR_IDLE :
                            asr_pkg::ASR_RELEASING;
            end
         end
         asr_pkg::ASR_RELEASING: begin
            if (cond) begin
               next_state = asr_pkg::ASR_ACTIVE;
            end else if (tick) begin
               next_cnt = cnt + 16'h0001;
               if (next_cnt >= cfg.release_dly) begin
                  next_state = asr_pkg::ASR_IDLE;
               end
            end
         end
      endcase
   end

   assign active = (state == asr_pkg::ASR_ACTIVE) || (state == asr_pkg::ASR_RELEASING);

   // State registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         hi_flag <= 1'b0;
         lo_flag <= 1'b0;
         state <= asr_pkg::ASR_IDLE;
         cnt <= '0;
      end else begin
         hi_flag <= next_hi_flag;
         lo_flag <= next_lo_flag;
         state <= next_state;
         cnt <= next_cnt;
      end
   end

   a_upper_set_level: assert property (@(posedge clk) disable iff (sys_rst)
      cfg.hi_en && (val_x >= hi_x) |=> hi_flag)
      else $error("upper level missed");
   a_lower_set_level: assert property (@(posedge clk) disable iff (sys_rst)
      cfg.lo_en && (val_x <= lo_x) |=> lo_flag)
      else $error("lower level missed");
   a_disabled_no_flag: assert property (@(posedge clk) disable iff (sys_rst)
      !cfg.hi_en ##1 !cfg.hi_en |-> !hi_flag)
      else $error("disabled setpoint flagged");
   a_upper_hold_band: assert property (@(posedge clk) disable iff (sys_rst)
      hi_flag && cfg.hi_en && (val_x >= hi_x - band_x) |=> hi_flag)
      else $error("upper flag released early");
   a_lower_hold_band: assert property (@(posedge clk) disable iff (sys_rst)
      lo_flag && cfg.lo_en && (val_x <= lo_x + band_x) |=> lo_flag)
      else $error("lower flag released early");
   a_trip_restart: assert property (@(posedge clk) disable iff (sys_rst)
      (state == asr_pkg::ASR_TRIPPING) && !cond |=> !active && (state == asr_pkg::ASR_IDLE))
      else $error("trip timer not restarted");
   a_release_restart: assert property (@(posedge clk) disable iff (sys_rst)
      (state == asr_pkg::ASR_RELEASING) && cond |=> state == asr_pkg::ASR_ACTIVE)
      else $error("release timer not restarted");

endmodule // asr_chan

// ### logic/asr_pi_mem.sv
// Small word memory for the control parameters of the first alarms.
// Assumes one write and one read port on clk; read data are registered.
`timescale 1ns/1ps
`include "asr_map.svh"

module asr_pi_mem #(
   parameter int unsigned WIDTH = `ASR_PI_W,
   parameter int unsigned DEPTH = 32
) (
   input wire logic clk, // System clock
   input wire logic sys_rst, // Synchronous reset, active high
   input wire logic wr_en, // Write strobe
   input wire logic [$clog2(DEPTH)-1:0] wr_addr, // Write word address
   input wire logic [WIDTH-1:0] wr_data, // Write data
   input wire logic rd_en, // Read strobe
   input wire logic [$clog2(DEPTH)-1:0] rd_addr, // Read word address
   output logic [WIDTH-1:0] rd_data // Read data, one cycle after rd_en
);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [WIDTH-1:0] next_rd_data;

   // Read data held until the next read
   always_comb begin
      next_rd_data = rd_data;
      if (rd_en) begin
         next_rd_data = mem[rd_addr];
      end
   end

   // Array has no reset; the owner tracks which words were ever written
   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      if (sys_rst) begin
         rd_data <= '0;
      end else begin
         rd_data <= next_rd_data;
      end
   end

endmodule // asr_pi_mem

// ### logic/asr_top.sv
// Alarm setpoint and relay logic for eight alarm channels: register port,
// delay time base, relay drive, annunciator flash and acknowledge.
// Assumes value comes from logic on clk; the acknowledge button is a raw pin.
//
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "asr_map.svh"

module asr_top #(
   parameter int unsigned TICK_CYCLES = `ASR_TICK_NS / `ASR_CLK_NS
) (
   input wire logic clk, // System clock, 10 MHz
   input wire logic sys_rst, // Synchronous reset, active high
   input wire logic signed [`ASR_VAL_W-1:0] value, // Displayed value
   input wire logic ack_button, // Acknowledge push button, raw pin
   input wire logic [9:0] addr, // Register byte address
   input wire logic [31:0] wdata, // Register write data
   input wire logic wr, // Write strobe
   input wire logic rd, // Read strobe
   output logic [31:0] rdata, // Read data, cycle after rd
   output logic [`ASR_RELAYS-1:0] relay, // Relay energise outputs
   output logic [`ASR_ALARMS-1:0] annunciator, // Front panel alarm lamps
   output logic [`ASR_ALARMS-1:0] alarm_active // Delayed alarm states
);

   localparam int TW = $clog2(TICK_CYCLES + 1);
   localparam int NA = `ASR_ALARMS;
   localparam int MW = $clog2(`ASR_PI_ALARMS) + 4;

   // Register storage
   asr_pkg::asr_cfg_t cfg [NA];
   asr_pkg::asr_cfg_t next_cfg [NA];
   logic [NA-1:0] cond, active;

   // Time base
   logic [TW-1:0] tick_cnt, next_tick_cnt;
   logic tick, next_tick;
   logic [2:0] flash_cnt, next_flash_cnt;
   logic flash, next_flash;

   // Acknowledge synchroniser and edge
   logic ack_meta, ack_sync, ack_prev;
   logic ack_pulse;

   // Annunciator and relay state
   logic [NA-1:0] acked, next_acked;
   logic [NA-1:0] next_annunciator;
   logic [`ASR_RELAYS-1:0] next_relay;

   // Bus decode
   logic sel_alarm, sel_pi, pi_idx_ok;
   logic [2:0] a_idx;
   logic [2:0] f_idx;
   logic [MW-1:0] pi_addr;
   logic [`ASR_PI_ALARMS*16-1:0] pi_written, next_pi_written;
   logic [31:0] reg_rdata, next_reg_rdata;
   logic rd_mem, next_rd_mem;
   logic [`ASR_PI_W-1:0] pi_dflt, next_pi_dflt;
   logic pi_fresh, next_pi_fresh;
   logic [`ASR_PI_W-1:0] mem_rdata;

   assign sel_alarm = (addr[9:8] == `ASR_REGION_ALARM);
   assign sel_pi = (addr[9:8] == `ASR_REGION_PI) && (addr[7] == 1'b0);
   assign a_idx = addr[7:5];
   assign f_idx = addr[4:2];
   assign pi_addr = addr[MW+1:2];
   assign pi_idx_ok = sel_pi && (addr[5:2] < 4'(`ASR_PI_WORDS));

   // Clamp a written time or deadband to its documented maximum
   function automatic logic [15:0] clamp16(input logic [31:0] d, input logic [15:0] lim);
      clamp16 = (d > {16'h0000, lim}) ? lim : d[15:0];
   endfunction

   // Reset value of a control parameter word
   function automatic logic [15:0] pi_reset(input logic [3:0] idx);
      unique case (idx)
         `ASR_PI_SPAN: pi_reset = `ASR_RST_SPAN;
         `ASR_PI_TARGET: pi_reset = `ASR_RST_TARGET;
         `ASR_PI_PGAIN: pi_reset = `ASR_RST_PGAIN;
         `ASR_PI_IHIGH: pi_reset = `ASR_RST_ILIMIT;
         `ASR_PI_ILOW: pi_reset = `ASR_RST_ILIMIT;
         `ASR_PI_BIAS: pi_reset = `ASR_RST_BIAS;
         default: pi_reset = 16'h0000;
      endcase
   endfunction

   // Percent words limit to 100.0, times to 5000.0 s
   function automatic logic [15:0] pi_clamp(input logic [3:0] idx, input logic [31:0] d);
      unique case (idx)
         `ASR_PI_IHIGH, `ASR_PI_ILOW, `ASR_PI_BIAS: pi_clamp = clamp16(d, `ASR_RST_ILIMIT);
         `ASR_PI_CYCLE, `ASR_PI_ONTIME: pi_clamp = clamp16(d, `ASR_MAX_TIME);
         default: pi_clamp = d[15:0];
      endcase
   endfunction

   // Per-alarm settings: writes land on the addressed alarm only
   always_comb begin
      for (int i = 0; i < NA; i++) begin
         next_cfg[i] = cfg[i];
         if (wr && sel_alarm && (a_idx == 3'(i))) begin
            unique case (f_idx)
               `ASR_F_UPPER: next_cfg[i].hi = wdata[`ASR_VAL_W-1:0];
               `ASR_F_LOWER: next_cfg[i].lo = wdata[`ASR_VAL_W-1:0];
               `ASR_F_ENABLE: begin
                  next_cfg[i].hi_en = wdata[`ASR_EN_UPPER_BIT];
                  next_cfg[i].lo_en = wdata[`ASR_EN_LOWER_BIT];
               end
               `ASR_F_DEADBAND: next_cfg[i].deadband_amount =
                  clamp16(wdata, `ASR_MAX_DEADBAND);
               `ASR_F_TRIP: next_cfg[i].trip = clamp16(wdata, `ASR_MAX_TIME);
               `ASR_F_RELEASE: next_cfg[i].release_dly = clamp16(wdata, `ASR_MAX_TIME);
               `ASR_F_ALLOC: next_cfg[i].relay_allocation = wdata[`ASR_RELAYS-1:0];
               `ASR_F_STATUS: next_cfg[i] = cfg[i];
            endcase
         end
      end
   end

   // Settings registers; both levels start disabled
   always_ff @(posedge clk) begin
      for (int i = 0; i < NA; i++) begin
         if (sys_rst) begin
            cfg[i] <= '0;
            cfg[i].deadband_amount <= `ASR_RST_DEADBAND;
         end else begin
            cfg[i] <= next_cfg[i];
         end
      end
   end

   // Read path: alarm words from a register, control words from memory
   always_comb begin
      next_reg_rdata = 32'h0000_0000;
      next_rd_mem = 1'b0;
      next_pi_fresh = 1'b0;
      next_pi_dflt = pi_reset(addr[5:2]);
      next_pi_written = pi_written;
      if (wr && pi_idx_ok) begin
         next_pi_written[pi_addr] = 1'b1;
      end
      if (rd && sel_alarm) begin
         unique case (f_idx)
            `ASR_F_UPPER: next_reg_rdata = 32'(cfg[a_idx].hi);
            `ASR_F_LOWER: next_reg_rdata = 32'(cfg[a_idx].lo);
            `ASR_F_ENABLE: next_reg_rdata = {30'h0000_0000, cfg[a_idx].lo_en, cfg[a_idx].hi_en};
            `ASR_F_DEADBAND: next_reg_rdata = {16'h0000, cfg[a_idx].deadband_amount};
            `ASR_F_TRIP: next_reg_rdata = {16'h0000, cfg[a_idx].trip};
            `ASR_F_RELEASE: next_reg_rdata = {16'h0000, cfg[a_idx].release_dly};
            `ASR_F_ALLOC: next_reg_rdata = 32'(cfg[a_idx].relay_allocation);
            `ASR_F_STATUS: next_reg_rdata = {28'h000_0000, annunciator[a_idx], acked[a_idx],
                                            active[a_idx], cond[a_idx]};
         endcase
      end else if (rd && pi_idx_ok) begin
         next_rd_mem = 1'b1;
         next_pi_fresh = !pi_written[pi_addr];
      end
   end

   // Read registers; the memory supplies its own registered word
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         reg_rdata <= 32'h0000_0000;
         rd_mem <= 1'b0;
         pi_fresh <= 1'b0;
         pi_dflt <= 16'h0000;
         pi_written <= '0;
      end else begin
         reg_rdata <= next_reg_rdata;
         rd_mem <= next_rd_mem;
         pi_fresh <= next_pi_fresh;
         pi_dflt <= next_pi_dflt;
         pi_written <= next_pi_written;
      end
   end

   // Words never written since reset read as their reset value
   assign rdata = !rd_mem ? reg_rdata :
                  {16'h0000, (pi_fresh ? pi_dflt : mem_rdata)};

   // Control parameters for the first two alarms only
   asr_pi_mem #(
      .WIDTH(`ASR_PI_W),
      .DEPTH(1 << MW)
   ) u_pi_mem (
      .clk(clk),
      .sys_rst(sys_rst),
      .wr_en(wr && pi_idx_ok),
      .wr_addr(pi_addr),
      .wr_data(pi_clamp(addr[5:2], wdata)),
      .rd_en(rd && pi_idx_ok),
      .rd_addr(pi_addr),
      .rd_data(mem_rdata)
   );

   // Alarm channels, one per alarm
   generate
      for (genvar g = 0; g < NA; g++) begin : g_chan
         asr_chan u_chan (
            .clk(clk),
            .sys_rst(sys_rst),
            .value(value),
            .cfg(cfg[g]),
            .tick(tick),
            .cond(cond[g]),
            .active(active[g])
         );
      end
   endgenerate

   // Delay tick and flash phase, both from the system clock
   always_comb begin
      next_tick = (tick_cnt == TW'(TICK_CYCLES - 1));
      next_tick_cnt = next_tick ? '0 : tick_cnt + 1'b1;
      next_flash_cnt = flash_cnt;
      next_flash = flash;
      if (tick) begin
         if (flash_cnt == `ASR_FLASH_TICKS - 3'h1) begin
            next_flash_cnt = 3'h0;
            next_flash = !flash;
         end else begin
            next_flash_cnt = flash_cnt + 3'h1;
         end
      end
   end

   // Time base registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         tick_cnt <= '0;
         tick <= 1'b0;
         flash_cnt <= 3'h0;
         flash <= 1'b0;
      end else begin
         tick_cnt <= next_tick_cnt;
         tick <= next_tick;
         flash_cnt <= next_flash_cnt;
         flash <= next_flash;
      end
   end

   // Button is asynchronous; only the second stage feeds the edge detect
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ack_meta <= 1'b0;
         ack_sync <= 1'b0;
         ack_prev <= 1'b0;
      end else begin
         ack_meta <= ack_button;
         ack_sync <= ack_meta;
         ack_prev <= ack_sync;
      end
   end

   assign ack_pulse = ack_sync && !ack_prev;

   // Acknowledge holds only while the alarm stays active, so a new alarm flashes
   always_comb begin
      next_acked = (acked | ({NA{ack_pulse}} & active)) & active;
      next_annunciator = active & (next_acked | {NA{flash}});
   end

   // Relay drive: any active alarm energises each relay it is allocated
   always_comb begin
      next_relay = '0;
      for (int i = 0; i < NA; i++) begin
         if (active[i]) begin
            next_relay = next_relay | cfg[i].relay_allocation;
         end
      end
   end

   // Output registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         acked <= '0;
         annunciator <= '0;
         relay <= '0;
         alarm_active <= '0;
      end else begin
         acked <= next_acked;
         annunciator <= next_annunciator;
         relay <= next_relay;
         alarm_active <= active;
      end
   end

   // Relay and delay checks; alarm 0 stands for all channels since they are one design
   a_relay_follows_alarm: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(active[0]) && cfg[0].relay_allocation[0] |=> relay[0])
      else $error("allocated relay not energised");
   a_relay_idle_off: assert property (@(posedge clk) disable iff (sys_rst)
      (active == '0) |=> (relay == '0))
      else $error("relay on with no alarm");
   // Edge of the condition, not its level, so a reprogrammed delay mid-count is not flagged
   a_trip_zero_delay: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(cond[0]) && (cfg[0].trip == '0) |=> active[0])
      else $error("zero trip delay not immediate");
   a_release_zero_delay: assert property (@(posedge clk) disable iff (sys_rst)
      $fell(cond[0]) && active[0] && (cfg[0].release_dly == '0) |=> !active[0])
      else $error("zero release delay held output");

   // Lamp behaviour: flash until acknowledged, then steady, dark when the alarm ends
   a_lamp_steady_acked: assert property (@(posedge clk) disable iff (sys_rst)
      acked[0] && active[0] ##1 active[0] |-> annunciator[0])
      else $error("acknowledged lamp not steady");
   a_lamp_off_idle: assert property (@(posedge clk) disable iff (sys_rst)
      !active[0] |=> !annunciator[0] && !acked[0])
      else $error("lamp lit with alarm off");
   a_ack_takes_hold: assert property (@(posedge clk) disable iff (sys_rst)
      ack_pulse && active[0] |=> acked[0])
      else $error("acknowledge not taken");
   a_lamp_flash_unacked: assert property (@(posedge clk) disable iff (sys_rst)
      active[0] && !acked[0] && !ack_pulse |=> annunciator[0] == $past(flash))
      else $error("unacknowledged lamp not flashing");

   // Tick and its counter restart together, so delays never drift by a cycle
   a_tick_spacing: assert property (@(posedge clk) disable iff (sys_rst)
      tick |=> !tick)
      else $error("tick longer than one cycle");
   a_tick_restarts_count: assert property (@(posedge clk) disable iff (sys_rst)
      tick |-> tick_cnt == '0)
      else $error("tick out of step with counter");

endmodule // asr_top

// ### verification/asr_panel.sv
// Panel model: the operator's acknowledge push button.
// Assumes press is a one-cycle request from the bench on clk.
`timescale 1ns/1ps

module asr_panel (
   input wire logic clk, // System clock
   input wire logic press, // Request one button press
   output logic ack_button // Button contact, high while pressed
);
   int hold = 0;
   // Contact held 8 cycles so the two sync flops surely see it
   always @(posedge clk) begin
      if (press) hold <= 8;
      else if (hold > 0) hold <= hold - 1;
   end
   assign ack_button = (hold > 0);
endmodule // asr_panel

// ### verification/tb_top.sv
// Bench: register port, alarm 0 levels, delays, relays and acknowledge.
// Assumes TICK_CYCLES of 10, so one delay unit is 10 clock cycles.
`timescale 1ns/1ps
`include "asr_map.svh"

module tb_top;
   logic clk = 0, sys_rst = 1, wr = 0, rd = 0, press = 0, ack_button;
   logic signed [`ASR_VAL_W-1:0] value = 0;
   logic [9:0] addr = 0;
   logic [31:0] wdata = 0, rdata;
   logic [6:0] relay;
   logic [7:0] annunciator, alarm_active;
   int miscompares = 0, checks = 0, n;
   always #50 clk = ~clk;
   asr_top #(.TICK_CYCLES(10)) asr_top_inst (.clk(clk), .sys_rst(sys_rst),
      .value(value), .ack_button(ack_button), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .relay(relay),
      .annunciator(annunciator), .alarm_active(alarm_active));
   asr_panel asr_panel_inst (.clk(clk), .press(press), .ack_button(ack_button));
   // Compare one result, report at once
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [9:0] a, input logic [31:0] d);
      @(posedge clk) begin addr <= a; wdata <= d; wr <= 1; end
      @(posedge clk) wr <= 0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd_chk(input logic [9:0] a, input logic [31:0] exp);
      @(posedge clk) begin addr <= a; rd <= 1; end
      @(posedge clk) rd <= 0;
      #1 chk(rdata, exp);
   endtask
   // Three cycles from value to output, one spare
   task automatic step(input int v, input logic exp);
      @(posedge clk) value <= v;
      repeat (4) @(posedge clk);
      #1 chk(alarm_active[0], exp);
   endtask
   task automatic wait_cyc(input int c);
      repeat (c) @(posedge clk);
   endtask
   // Bounded wait for alarm 0 to reach a state; n holds the cycles
   task automatic wait_for(input logic exp, input int lim);
      for (n = 0; n < lim && alarm_active[0] !== exp; n++) @(posedge clk);
      if (alarm_active[0] !== exp) begin
         chk(alarm_active[0], exp);
         end_sim();
      end
   endtask
   task automatic t_reset;
      rd_chk(10'h00C, 32'h0000_000A);
      rd_chk(10'h008, 32'h0000_0000);
      rd_chk(10'h018, 32'h0000_0000);
      rd_chk(10'h100, 32'h0000_03E8);
      rd_chk(10'h144, 32'h0000_03E8);
      rd_chk(10'h110, 32'h0000_03E8);
      rd_chk(10'h118, 32'h0000_01F4);
      rd_chk(10'h11C, 32'h0000_0000);
      rd_chk(10'h120, 32'h0000_0000);
      rd_chk(10'h180, 32'h0000_0000);
      wr_reg(10'h110, 32'h0000_07D0);
      rd_chk(10'h110, 32'h0000_03E8);
      rd_chk(10'h150, 32'h0000_03E8);
      wr_reg(10'h02C, 32'h0000_0014);
      rd_chk(10'h02C, 32'h0000_0014);
      rd_chk(10'h00C, 32'h0000_000A);
      wr_reg(10'h00C, 32'h0000_EA60);
      rd_chk(10'h00C, 32'h0000_C350);
      wr_reg(10'h00C, 32'h0000_000A);
   endtask
   task automatic t_levels;
      wr_reg(10'h000, 100);
      wr_reg(10'h018, 32'h0000_0005);
      wr_reg(10'h008, 32'h0000_0001);
      step(99, 0);
      step(100, 1);
      chk(relay, 7'h05);
      chk(alarm_active, 8'h01);
      step(90, 1);
      step(89, 0);
      chk(relay, 7'h00);
      wr_reg(10'h004, 20);
      wr_reg(10'h008, 32'h0000_0002);
      step(21, 0);
      step(20, 1);
      step(30, 1);
      step(31, 0);
      wr_reg(10'h008, 32'h0000_0003);
      step(50, 0);
      step(10, 1);
      wr_reg(10'h000, 20);
      wr_reg(10'h004, 100);
      step(50, 1);
      step(150, 0);
   endtask
   task automatic t_delays;
      step(0, 0);
      wr_reg(10'h008, 32'h0000_0001);
      wr_reg(10'h000, 100);
      wr_reg(10'h010, 3);
      wr_reg(10'h014, 3);
      step(0, 0);
      @(posedge clk) value <= 100;
      wait_cyc(15);
      #1 chk(alarm_active[0], 0);
      @(posedge clk) value <= 0;
      wait_cyc(2);
      @(posedge clk) value <= 100;
      wait_for(1, 60);
      chk(n >= 20 && n <= 34, 1);
      @(posedge clk) value <= 0;
      wait_cyc(8);
      @(posedge clk) value <= 100;
      wait_cyc(3);
      @(posedge clk) value <= 0;
      wait_cyc(22);
      #1 chk(alarm_active[0], 1);
      wait_for(0, 20);
   endtask
   task automatic t_ack;
      wr_reg(10'h010, 0);
      wr_reg(10'h014, 0);
      step(100, 1);
      for (n = 0; n < 60 && annunciator[0] !== 0; n++) @(posedge clk);
      chk(annunciator[0], 0);
      if (annunciator[0] !== 0) end_sim();
      @(posedge clk) press <= 1;
      @(posedge clk) press <= 0;
      wait_cyc(12);
      rd_chk(10'h01C, 32'h0000_000F);
      wait_cyc(30);
      #1 chk(annunciator[0], 1);
      step(0, 0);
      chk(annunciator[0], 0);
      chk(relay, 7'h00);
   endtask
   task automatic end_sim;
      $display("checks=%0d miscompares=%0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      wait_cyc(16);
      sys_rst <= 0;
      t_reset();
      t_levels();
      t_delays();
      t_ack();
      end_sim();
   end
endmodule // tb_top
